// ==== design/clock_event_map.svh ====
`ifndef CLOCK_EVENT_MAP_SVH
`define CLOCK_EVENT_MAP_SVH

// Register offsets
`define CE_OFS_HF_STARTED 12'h100
`define CE_OFS_LF_STARTED 12'h104
`define CE_OFS_RC_CAL_DONE 12'h10C
`define CE_OFS_CAL_TIMEOUT 12'h110
`define CE_OFS_IRQ_SET 12'h304
`define CE_OFS_IRQ_CLR 12'h308
`define CE_OFS_HF_RUN 12'h408

// Field positions and widths
`define CE_EVENT_BIT 0
`define CE_STATUS_BIT 0
`define CE_NUM_EVENTS 4
`define CE_ADDR_W 12
`define CE_DATA_W 32

// Reset values
`define CE_EVENTS_RESET 4'h0
`define CE_ENABLE_RESET 4'h0
`define CE_DATA_ZERO 32'h00000000

`endif

// ==== design/clock_event_pkg.sv ====
`include "clock_event_map.svh"

package clock_event_pkg;

   // Bit order follows the enable registers: listed from bit 3 down to bit 0
   typedef struct packed {
      logic calTimerTimeout;
      logic rcCalibrationDone;
      logic lfClockStarted;
      logic hfClockStarted;
   } clock_events_t;

   typedef struct packed {
      logic hfClockStartTask;
      logic hfClockStopTask;
      logic calTimerStartTask;
      logic calTimerStopTask;
   } clock_tasks_t;

   typedef struct packed {
      logic [`CE_ADDR_W-1:0] addr;
      logic [`CE_DATA_W-1:0] wdata;
      logic write;
      logic read;
   } reg_req_t;

endpackage

// ==== design/clock_event_irq_status.sv ====
`timescale 1ns/100ps
`include "clock_event_map.svh"

module clock_event_irq_status (
   input wire logic ref_clk,
   input wire logic reset,
   input wire clock_event_pkg::reg_req_t regReq,
   output logic [`CE_DATA_W-1:0] regRData,
   input wire clock_event_pkg::clock_events_t eventPulse,
   input wire clock_event_pkg::clock_tasks_t taskPulse,
   output logic irq
);

   clock_event_pkg::clock_events_t events_reg, events_next;
   clock_event_pkg::clock_events_t irqEnable_reg, irqEnable_next;
   logic hfStartRequested_reg, hfStartRequested_next;
   logic calTimerRunning_reg, calTimerRunning_next;
   logic [`CE_DATA_W-1:0] regRData_reg, regRData_next;
   logic irq_reg, irq_next;
   logic [`CE_NUM_EVENTS-1:0] evWrite;
   logic [`CE_NUM_EVENTS-1:0] evPulse;
   logic [`CE_NUM_EVENTS-1:0] evNext;

   assign regRData = regRData_reg;
   assign irq = irq_reg;

   // Timeout only counts from a timer that software has started
   // started timer only
   always_comb begin
      calTimerRunning_next = calTimerRunning_reg;
      if (taskPulse.calTimerStopTask || eventPulse.calTimerTimeout) begin
         calTimerRunning_next = 1'b0;
      end
      if (taskPulse.calTimerStartTask) begin
         calTimerRunning_next = 1'b1;
      end
   end

   always_comb begin
      evWrite[0] = regReq.write && regReq.addr == `CE_OFS_HF_STARTED;
      evWrite[1] = regReq.write && regReq.addr == `CE_OFS_LF_STARTED;
      evWrite[2] = regReq.write && regReq.addr == `CE_OFS_RC_CAL_DONE;
      evWrite[3] = regReq.write && regReq.addr == `CE_OFS_CAL_TIMEOUT;
      evPulse = eventPulse;
      evPulse[3] = eventPulse.calTimerTimeout && calTimerRunning_reg;
   end

   // Event flags: a write stores bit 0, a hardware event in the same cycle wins
   // event flag storage
   genvar gi;
   generate
      for (gi = 0; gi < `CE_NUM_EVENTS; gi++) begin : g_event
         always_comb begin
            evNext[gi] = evWrite[gi] ? regReq.wdata[`CE_EVENT_BIT] : events_reg[gi];
            if (evPulse[gi]) begin
               evNext[gi] = 1'b1;
            end
         end
      end
   endgenerate

   always_comb begin
      events_next = evNext;
   end

   always_comb begin
      irqEnable_next = irqEnable_reg;
      if (regReq.write && regReq.addr == `CE_OFS_IRQ_SET) begin
         irqEnable_next = irqEnable_reg | regReq.wdata[`CE_NUM_EVENTS-1:0];
      end else if (regReq.write && regReq.addr == `CE_OFS_IRQ_CLR) begin
         irqEnable_next = irqEnable_reg & ~regReq.wdata[`CE_NUM_EVENTS-1:0];
      end
   end

   // Stop task drops the status so a later start shows again
   // start task status
   always_comb begin
      hfStartRequested_next = hfStartRequested_reg;
      if (taskPulse.hfClockStopTask) begin
         hfStartRequested_next = 1'b0;
      end
      if (taskPulse.hfClockStartTask) begin
         hfStartRequested_next = 1'b1;
      end
   end

   always_comb begin
      regRData_next = `CE_DATA_ZERO;
      if (regReq.read) begin
         case (regReq.addr)
            `CE_OFS_HF_STARTED: regRData_next[`CE_EVENT_BIT] = events_reg.hfClockStarted;
            `CE_OFS_LF_STARTED: regRData_next[`CE_EVENT_BIT] = events_reg.lfClockStarted;
            `CE_OFS_RC_CAL_DONE: regRData_next[`CE_EVENT_BIT] = events_reg.rcCalibrationDone;
            `CE_OFS_CAL_TIMEOUT: regRData_next[`CE_EVENT_BIT] = events_reg.calTimerTimeout;
            `CE_OFS_IRQ_SET, `CE_OFS_IRQ_CLR: begin
               regRData_next[`CE_NUM_EVENTS-1:0] = irqEnable_reg;
            end
            `CE_OFS_HF_RUN: regRData_next[`CE_STATUS_BIT] = hfStartRequested_reg;
            default: regRData_next = `CE_DATA_ZERO;
         endcase
      end
   end

   // Level from registered state; follows flags one cycle late
   always_comb begin
      irq_next = |(events_reg & irqEnable_reg);
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         events_reg <= `CE_EVENTS_RESET;
         irqEnable_reg <= `CE_ENABLE_RESET;
         hfStartRequested_reg <= 1'b0;
         calTimerRunning_reg <= 1'b0;
         regRData_reg <= `CE_DATA_ZERO;
         irq_reg <= 1'b0;
      end else begin
         events_reg <= events_next;
         irqEnable_reg <= irqEnable_next;
         hfStartRequested_reg <= hfStartRequested_next;
         calTimerRunning_reg <= calTimerRunning_next;
         regRData_reg <= regRData_next;
         irq_reg <= irq_next;
      end
   end

   sequence s_write_at(logic [`CE_ADDR_W-1:0] a);
      regReq.write && regReq.addr == a;
   endsequence

   sequence s_read_at(logic [`CE_ADDR_W-1:0] a);
      regReq.read && regReq.addr == a;
   endsequence

   sequence s_enable_read;
      regReq.read && (regReq.addr == `CE_OFS_IRQ_SET || regReq.addr == `CE_OFS_IRQ_CLR);
   endsequence

   // Software write to a flag with no hardware event beside it
   sequence s_done_write_alone;
      s_write_at(`CE_OFS_RC_CAL_DONE) ##0 !eventPulse.rcCalibrationDone;
   endsequence

   sequence s_timeout_write_alone;
      s_write_at(`CE_OFS_CAL_TIMEOUT) ##0 !(eventPulse.calTimerTimeout && calTimerRunning_reg);
   endsequence

   a_enable_set_write: assert property (@(posedge ref_clk) disable iff (reset)
      s_write_at(`CE_OFS_IRQ_SET) |=>
      ((irqEnable_reg & $past(regReq.wdata[`CE_NUM_EVENTS-1:0]))
       == $past(regReq.wdata[`CE_NUM_EVENTS-1:0])))
      else $error("enable set write did not enable bits");

   a_enable_clear_write: assert property (@(posedge ref_clk) disable iff (reset)
      s_write_at(`CE_OFS_IRQ_CLR) |=>
      ((irqEnable_reg & $past(regReq.wdata[`CE_NUM_EVENTS-1:0])) == `CE_ENABLE_RESET))
      else $error("enable clear write left bits set");

   a_enable_read_shared: assert property (@(posedge ref_clk) disable iff (reset)
      s_enable_read |=>
      regRData == {28'h0000000, $past(irqEnable_reg)})
      else $error("enable read mismatch");

   a_hf_status_set: assert property (@(posedge ref_clk) disable iff (reset)
      taskPulse.hfClockStartTask |=> hfStartRequested_reg)
      else $error("start task status not set");

   a_hf_status_clear: assert property (@(posedge ref_clk) disable iff (reset)
      taskPulse.hfClockStopTask && !taskPulse.hfClockStartTask |=> !hfStartRequested_reg)
      else $error("start task status not cleared by stop");

   a_hf_status_read: assert property (@(posedge ref_clk) disable iff (reset)
      s_read_at(`CE_OFS_HF_RUN) |=>
      regRData[`CE_STATUS_BIT] == $past(hfStartRequested_reg))
      else $error("start task status not read back");

   a_timeout_event_set: assert property (@(posedge ref_clk) disable iff (reset)
      eventPulse.calTimerTimeout && calTimerRunning_reg |=> events_reg.calTimerTimeout)
      else $error("timeout flag not set");

   a_timeout_write: assert property (@(posedge ref_clk) disable iff (reset)
      s_timeout_write_alone |=>
      events_reg.calTimerTimeout == $past(regReq.wdata[`CE_EVENT_BIT]))
      else $error("timeout flag write not stored");

   a_timeout_needs_start: assert property (@(posedge ref_clk) disable iff (reset)
      !calTimerRunning_reg && !events_reg.calTimerTimeout
      && !(regReq.write && regReq.addr == `CE_OFS_CAL_TIMEOUT)
      |=> !events_reg.calTimerTimeout)
      else $error("timeout without started timer");

   a_timer_stop_disarms: assert property (@(posedge ref_clk) disable iff (reset)
      taskPulse.calTimerStopTask && !taskPulse.calTimerStartTask |=> !calTimerRunning_reg)
      else $error("stopped timer still armed");

   a_hf_event_set: assert property (@(posedge ref_clk) disable iff (reset)
      eventPulse.hfClockStarted |=> events_reg.hfClockStarted)
      else $error("HF started flag not set");

   a_hf_event_read: assert property (@(posedge ref_clk) disable iff (reset)
      s_read_at(`CE_OFS_HF_STARTED) |=>
      regRData[`CE_EVENT_BIT] == $past(events_reg.hfClockStarted))
      else $error("HF started flag not readable");

   a_done_event_set: assert property (@(posedge ref_clk) disable iff (reset)
      eventPulse.rcCalibrationDone |=> events_reg.rcCalibrationDone)
      else $error("calibration done flag not set");

   a_done_write: assert property (@(posedge ref_clk) disable iff (reset)
      s_done_write_alone |=>
      events_reg.rcCalibrationDone == $past(regReq.wdata[`CE_EVENT_BIT]))
      else $error("calibration done write not stored");

   a_irq_follows: assert property (@(posedge ref_clk) disable iff (reset)
      |(events_reg & irqEnable_reg) |=> irq)
      else $error("interrupt not raised for enabled event");

   a_irq_drops: assert property (@(posedge ref_clk) disable iff (reset)
      !(|(events_reg & irqEnable_reg)) |=> !irq)
      else $error("interrupt raised with no enabled event");

endmodule

// ==== tb/clock_event_irq_status_tb.sv ====
`timescale 1ns/100ps
`include "clock_event_map.svh"
module clock_event_irq_status_tb;
   logic ref_clk;
   logic reset;
   clock_event_pkg::reg_req_t regReq;
   logic [31:0] regRData;
   clock_event_pkg::clock_events_t eventPulse;
   clock_event_pkg::clock_tasks_t taskPulse;
   logic irq;
   int n_errors;
   int comparisons;
   int cycles;
   integer seed;
   logic [3:0] enModel;
   logic [31:0] rnd;
   logic [11:0] ofs [4] = '{`CE_OFS_HF_STARTED, `CE_OFS_LF_STARTED, `CE_OFS_RC_CAL_DONE,
      `CE_OFS_CAL_TIMEOUT};

   clock_event_irq_status clock_event_irq_status_i (
      .ref_clk(ref_clk),
      .reset(reset),
      .regReq(regReq),
      .regRData(regRData),
      .eventPulse(eventPulse),
      .taskPulse(taskPulse),
      .irq(irq)
   );

   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end

   function automatic logic [3:0] next_en(input logic [3:0] cur, input logic [3:0] d,
      input logic setOp);
      return setOp ? (cur | d) : (cur & ~d);
   endfunction

   task automatic tally_and_finish();
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      regReq <= '{addr: a, wdata: d, write: 1'b1, read: 1'b0};
      @(posedge ref_clk);
      regReq.write <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      @(posedge ref_clk);
      regReq <= '{addr: a, wdata: 32'h00000000, write: 1'b0, read: 1'b1};
      @(posedge ref_clk);
      regReq.read <= 1'b0;
      #1;
      chk($sformatf("reg %h", a), exp, regRData);
   endtask

   task automatic pulse(input logic [3:0] e, input logic [3:0] t);
      @(posedge ref_clk);
      eventPulse <= e;
      taskPulse <= t;
      @(posedge ref_clk);
      eventPulse <= 4'h0;
      taskPulse <= 4'h0;
   endtask

   task automatic irq_is(input logic exp);
      @(posedge ref_clk);
      #1;
      chk("irq", {31'h0, exp}, {31'h0, irq});
   endtask

   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         n_errors++;
         tally_and_finish();
      end
   end

   initial begin
      seed = 32'hB41A84D2;
      reset = 1'b1;
      regReq = '0;
      eventPulse = '0;
      taskPulse = '0;
      n_errors = 0;
      comparisons = 0;
      cycles = 0;
      enModel = 4'h0;
      repeat (12) @(posedge ref_clk);
      reset <= 1'b0;
      rd(`CE_OFS_IRQ_SET, 32'h00000000);
      rd(`CE_OFS_IRQ_CLR, 32'h00000000);
      rd(`CE_OFS_HF_RUN, 32'h00000000);
      rd(`CE_OFS_CAL_TIMEOUT, 32'h00000000);
      for (int i = 0; i < 3; i++) begin
         rd(ofs[i], 32'h00000000);
      end
      repeat (12) begin
         rnd = $random(seed);
         wr(`CE_OFS_IRQ_SET, {28'h0, rnd[3:0]});
         enModel = next_en(enModel, rnd[3:0], 1'b1);
         rd(`CE_OFS_IRQ_SET, {28'h0, enModel});
         wr(`CE_OFS_IRQ_CLR, {28'h0, rnd[7:4]});
         enModel = next_en(enModel, rnd[7:4], 1'b0);
         rd(`CE_OFS_IRQ_CLR, {28'h0, enModel});
      end
      wr(`CE_OFS_IRQ_SET, 32'h0000000F);
      for (int i = 0; i < 4; i++) begin
         if (i == 3) begin
            pulse(4'h8, 4'h0);
            rd(`CE_OFS_CAL_TIMEOUT, 32'h00000000);
            pulse(4'h0, 4'h2);
         end
         pulse(4'h1 << i, 4'h0);
         irq_is(1'b1);
         rd(ofs[i], 32'h00000001);
         wr(`CE_OFS_IRQ_CLR, 32'h00000001 << i);
         irq_is(1'b0);
         wr(`CE_OFS_IRQ_SET, 32'h00000001 << i);
         irq_is(1'b1);
         wr(ofs[i], 32'h00000000);
         irq_is(1'b0);
         rd(ofs[i], 32'h00000000);
      end
      // Status is read-only: a write must not set it
      wr(`CE_OFS_HF_RUN, 32'h00000001);
      rd(`CE_OFS_HF_RUN, 32'h00000000);
      pulse(4'h0, 4'h8);
      rd(`CE_OFS_HF_RUN, 32'h00000001);
      pulse(4'h0, 4'h4);
      rd(`CE_OFS_HF_RUN, 32'h00000000);
      // Start and stop together: start wins
      pulse(4'h0, 4'hC);
      rd(`CE_OFS_HF_RUN, 32'h00000001);
      wr(12'h200, 32'hFFFFFFFF);
      rd(12'h200, 32'h00000000);
      rd(`CE_OFS_IRQ_SET, 32'h0000000F);
      // The earlier timeout disarmed the timer; a stop task disarms it too
      pulse(4'h8, 4'h0);
      rd(`CE_OFS_CAL_TIMEOUT, 32'h00000000);
      pulse(4'h0, 4'h2);
      pulse(4'h0, 4'h1);
      pulse(4'h8, 4'h0);
      rd(`CE_OFS_CAL_TIMEOUT, 32'h00000000);
      // Event beside a clearing write: the event wins
      @(posedge ref_clk);
      regReq <= '{addr: `CE_OFS_RC_CAL_DONE, wdata: 32'h00000000, write: 1'b1, read: 1'b0};
      eventPulse <= 4'h4;
      @(posedge ref_clk);
      regReq.write <= 1'b0;
      eventPulse <= 4'h0;
      rd(`CE_OFS_RC_CAL_DONE, 32'h00000001);
      wr(`CE_OFS_RC_CAL_DONE, 32'h00000000);
      rd(`CE_OFS_RC_CAL_DONE, 32'h00000000);
      wr(`CE_OFS_RC_CAL_DONE, 32'h00000001);
      rd(`CE_OFS_RC_CAL_DONE, 32'h00000001);
      irq_is(1'b1);
      // Reset in mid-run clears enables, flags and status
      @(posedge ref_clk);
      reset <= 1'b1;
      repeat (2) @(posedge ref_clk);
      reset <= 1'b0;
      irq_is(1'b0);
      rd(`CE_OFS_IRQ_SET, 32'h00000000);
      rd(`CE_OFS_HF_RUN, 32'h00000000);
      rd(`CE_OFS_RC_CAL_DONE, 32'h00000000);
      tally_and_finish();
   end
endmodule
